// ### logic/ptb_chain.sv
// Divider chain of the timebase, advanced once per reference tick.
// Assumes tick_i is a one-cycle enable on clock_i.
`timescale 1ns/1ps
module ptb_chain #(
  parameter int STAGES = ptb_pkg::PTB_STAGES
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic enable_i,
  input wire logic tick_i,
  input wire logic [2:0] rate_i,
  output logic event_o,
  output logic [STAGES-1:0] count_o
);
  import ptb_pkg::*;

  logic [STAGES-1:0] count_q;
  logic [STAGES-1:0] tap_mask;
  logic [PTB_STAGE_IDX_W-1:0] tap;

  assign tap = ptb_tap_stage(rate_i);

  // Mask of stages below the tap, all ones means the tap is about to toggle
  for (genvar g = 0; g < STAGES; g++) begin : g_mask
    assign tap_mask[g] = (g < int'(tap));
  end

  // Cleared while disabled, counts from zero once enabled
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_q <= '0;
    end else if (!enable_i) begin
      count_q <= '0;
    end else if (tick_i) begin
      count_q <= count_q + 1'b1;
    end
  end

  // Tap rising edge: first at half the period, then once per full period
  assign event_o = enable_i && tick_i &&
                   ((count_q & tap_mask) == tap_mask) && !count_q[tap];
  assign count_o = count_q;

endmodule : ptb_chain

// ### logic/ptb_osc_tick.sv
// Oscillator reference tick: one-cycle enable per reference period.
// Assumes clock_i is the only clock; the reference is modelled as a rate.
`timescale 1ns/1ps
module ptb_osc_tick #(
  parameter int DIV = ptb_pkg::PTB_OSC_DIV
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic run_i,
  output logic tick_o
);
  import ptb_pkg::*;

  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] count_q;

  // Free divider, held idle when the reference is stopped to save power
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_q <= '0;
    end else if (!run_i || count_q == LAST) begin
      count_q <= '0;
    end else begin
      count_q <= count_q + 1'b1;
    end
  end

  assign tick_o = run_i && (count_q == LAST);

endmodule : ptb_osc_tick

// ### logic/ptb_pkg.sv
// Package for the periodic timebase interrupt block.
// Holds register offsets, field positions, reset values and tap table.
package ptb_pkg;

  // Register byte offsets on the APB word map
  localparam logic [7:0] PTB_OFS_CONTROL = 8'h00;
  localparam logic [7:0] PTB_OFS_STATUS = 8'h04;
  localparam logic [7:0] PTB_OFS_MASK = 8'h08;

  // timebase_control field positions
  localparam int PTB_BIT_RUN_ENABLE = 1;
  localparam int PTB_BIT_IRQ_ENABLE = 2;
  localparam int PTB_BIT_FLAG_ACK = 3;
  localparam int PTB_RATE_LSB = 4;
  localparam int PTB_RATE_W = 3;
  localparam int PTB_BIT_PENDING = 7;

  // Event status bits: flag set, flag set again while still pending
  localparam int PTB_EVT_W = 2;
  localparam int PTB_EVT_FLAG = 0;
  localparam int PTB_EVT_MISSED = 1;

  // Values after reset
  localparam logic [2:0] PTB_RATE_RST = 3'h0;
  localparam logic [PTB_EVT_W-1:0] PTB_MASK_RST = 2'h0;

  // Divider chain length
  localparam int PTB_STAGES = 18;
  localparam int PTB_STAGE_IDX_W = 5;

  // Clock rates: bus clock and oscillator reference, in Hz
  localparam int PTB_CLK_HZ = 40_000_000;
  localparam int PTB_OSC_HZ = 4_000_000;
  localparam int PTB_OSC_DIV = PTB_CLK_HZ / PTB_OSC_HZ;

  // Stage whose rising edge marks an event: division is 2^(stage+1)
  function automatic logic [PTB_STAGE_IDX_W-1:0] ptb_tap_stage(input logic [2:0] rate);
    case (rate)
      3'h0: ptb_tap_stage = 5'h11; // 262144
      3'h1: ptb_tap_stage = 5'h10; // 131072
      3'h2: ptb_tap_stage = 5'h0f; // 65536
      3'h3: ptb_tap_stage = 5'h0e; // 32768
      3'h4: ptb_tap_stage = 5'h05; // 64
      3'h5: ptb_tap_stage = 5'h04; // 32
      3'h6: ptb_tap_stage = 5'h03; // 16
      default: ptb_tap_stage = 5'h02; // 8
    endcase
  endfunction : ptb_tap_stage

endpackage : ptb_pkg

// ### logic/ptb_top.sv
// Periodic timebase interrupt: APB registers, pending flag and interrupts.
// Assumes an APB master on clock_i and low-power mode levels from the core.
//
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/1ps

module ptb_top #(
  parameter int OSC_DIV = ptb_pkg::PTB_OSC_DIV,
  parameter int STAGES = ptb_pkg::PTB_STAGES
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic wait_mode_i,
  input wire logic stop_mode_i,
  input wire logic osc_stop_keep_i,
  output logic irq_o,
  output logic wake_o
);
  import ptb_pkg::*;

  logic run_enable_q;
  logic irq_enable_q;
  logic [2:0] rate_select_q;
  logic pending_flag_q;
  logic [PTB_EVT_W-1:0] status_q;
  logic [PTB_EVT_W-1:0] mask_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic osc_run;
  logic osc_tick;
  logic tap_event;
  logic tb_irq;
  logic setup;
  logic access;
  logic locked;
  logic mapped;
  logic wr_ok;
  logic rd_ok;
  logic hit_ctrl;
  logic hit_stat;
  logic hit_mask;
  logic ack_wr;
  logic [7:0] ctrl_view;

  // Reference runs except in stop without the keep-alive option
  assign osc_run = !stop_mode_i || osc_stop_keep_i;

  ptb_osc_tick #(
    .DIV(OSC_DIV)
  ) u_tick (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .run_i(osc_run),
    .tick_o(osc_tick)
  );

  // One clock only, so the reference appears as an enable and no crossing is needed
  ptb_chain #(
    .STAGES(STAGES)
  ) u_chain (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .enable_i(run_enable_q),
    .tick_i(osc_tick),
    .rate_i(rate_select_q),
    .event_o(tap_event),
    .count_o()
  );

  // APB decode; registers refused in wait and stop
  assign setup = psel_i && !penable_i;
  assign access = psel_i && penable_i;
  assign locked = wait_mode_i || stop_mode_i;
  assign hit_ctrl = (paddr_i == PTB_OFS_CONTROL);
  assign hit_stat = (paddr_i == PTB_OFS_STATUS);
  assign hit_mask = (paddr_i == PTB_OFS_MASK);
  assign mapped = hit_ctrl || hit_stat || hit_mask;
  assign wr_ok = access && pwrite_i && mapped && !locked && pstrb_i[0];
  assign rd_ok = access && !pwrite_i && mapped && !locked;
  assign ack_wr = wr_ok && hit_ctrl && pwdata_i[PTB_BIT_FLAG_ACK];

  // Zero-wait slave: every access phase completes at once
  assign pready_o = 1'b1;
  assign pslverr_o = pslverr_q;
  assign prdata_o = prdata_q;

  // Control view; acknowledge bit always reads zero
  always_comb begin
    ctrl_view = 8'h00;
    ctrl_view[PTB_BIT_RUN_ENABLE] = run_enable_q;
    ctrl_view[PTB_BIT_IRQ_ENABLE] = irq_enable_q;
    ctrl_view[PTB_RATE_LSB +: PTB_RATE_W] = rate_select_q;
    ctrl_view[PTB_BIT_PENDING] = pending_flag_q;
  end

  // Control bits written over the bus
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run_enable_q <= 1'b0;
      irq_enable_q <= 1'b0;
      rate_select_q <= PTB_RATE_RST;
    end else if (wr_ok && hit_ctrl) begin
      run_enable_q <= pwdata_i[PTB_BIT_RUN_ENABLE];
      irq_enable_q <= pwdata_i[PTB_BIT_IRQ_ENABLE];
      rate_select_q <= pwdata_i[PTB_RATE_LSB +: PTB_RATE_W];
    end
  end

  // Pending flag; a rollover in the acknowledge cycle wins over the clear
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pending_flag_q <= 1'b0;
    end else if (tap_event) begin
      pending_flag_q <= 1'b1;
    end else if (ack_wr) begin
      pending_flag_q <= 1'b0;
    end
  end

  // Sticky event status, cleared by a read of it; new events win
  // Only bits already captured for the reader are cleared, so an event that
  // lands between setup and access is kept for the next read
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      status_q <= '0;
    end else begin
      for (int i = 0; i < PTB_EVT_W; i++) begin
        if (rd_ok && hit_stat && prdata_q[i]) begin
          status_q[i] <= 1'b0;
        end
      end
      if (tap_event) begin
        status_q[PTB_EVT_FLAG] <= 1'b1;
      end
      if (tap_event && pending_flag_q && !ack_wr) begin
        status_q[PTB_EVT_MISSED] <= 1'b1; // Previous event never acknowledged
      end
    end
  end

  // Event mask
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mask_q <= PTB_MASK_RST;
    end else if (wr_ok && hit_mask) begin
      mask_q <= pwdata_i[PTB_EVT_W-1:0];
    end
  end

  // Read data captured in setup so the access phase answers from flops
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (setup) begin
      pslverr_q <= !mapped || locked;
      if (!pwrite_i && hit_ctrl && !locked) begin
        prdata_q <= {24'h00_0000, ctrl_view};
      end else if (!pwrite_i && hit_stat && !locked) begin
        prdata_q <= {{(32-PTB_EVT_W){1'b0}}, status_q};
      end else if (!pwrite_i && hit_mask && !locked) begin
        prdata_q <= {{(32-PTB_EVT_W){1'b0}}, mask_q};
      end else begin
        prdata_q <= 32'h0000_0000;
      end
    end
  end

  // Request from the flag, or from any unmasked sticky event
  assign tb_irq = pending_flag_q && irq_enable_q;
  assign irq_o = tb_irq || |(status_q & mask_q);
  // Wake only meaningful while the chain still runs in stop
  assign wake_o = stop_mode_i && tb_irq;

endmodule : ptb_top

// ### sim/ptb_top_asserts.sv
// Checker for the periodic timebase: APB refusals, interrupt gating, timing.
// Assumes it is bound to ptb_top and sees only its ports.
`timescale 1ns/1ps
module ptb_top_asserts
  import ptb_pkg::*;
#(
  parameter int OSC_DIV = 1
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic wait_mode_i,
  input wire logic stop_mode_i,
  input wire logic osc_stop_keep_i,
  input wire logic irq_o,
  input wire logic wake_o
);
  logic run_q, ie_q, acc, wr_ok, wr_ctl, quiet;
  logic [1:0] mask_q, off_q;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  // Accepted writes, as software sees them
  assign acc = psel_i && penable_i;
  assign wr_ok = acc && pwrite_i && pstrb_i[0] && !wait_mode_i && !stop_mode_i;
  assign wr_ctl = wr_ok && paddr_i == PTB_OFS_CONTROL;
  assign quiet = ie_q && !irq_o && mask_q == 2'h0 && !(acc && pwrite_i);
  // Shadow of the written enables
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run_q <= 1'h0;
      ie_q <= 1'h0;
    end else if (wr_ctl) begin
      run_q <= pwdata_i[PTB_BIT_RUN_ENABLE];
      ie_q <= pwdata_i[PTB_BIT_IRQ_ENABLE];
    end
  end
  // Shadow of the mask register
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) mask_q <= 2'h0;
    else if (wr_ok && paddr_i == PTB_OFS_MASK) mask_q <= pwdata_i[1:0];
  end
  // Cycles spent stopped, saturating; lets tick pipelines drain
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) off_q <= 2'h0;
    else if (run_q) off_q <= 2'h0;
    else if (off_q != 2'h3) off_q <= off_q + 2'h1;
  end
  sequence s_start;
    wr_ctl && pwdata_i[PTB_BIT_RUN_ENABLE] && pwdata_i[6:4] == 3'h7 && !run_q
      && off_q >= 2'h2 && ie_q && !irq_o && mask_q == 2'h0
      && pwdata_i[PTB_BIT_IRQ_ENABLE] && OSC_DIV == 1;
  endsequence
  sequence s_half;
    !irq_o [*2] ##[1:6] irq_o;
  endsequence
  AST_MODE_ERR: assert property (acc && (wait_mode_i || stop_mode_i) |-> pslverr_o
    && prdata_o == 32'h0) else $error("mode access not refused");
  AST_ACK_READ0: assert property (acc && !pwrite_i && paddr_i == PTB_OFS_CONTROL
    |-> !prdata_o[PTB_BIT_FLAG_ACK]) else $error("ack bit read as one");
  AST_IRQ_GATE: assert property (!ie_q && mask_q == 2'h0 |-> !irq_o)
    else $error("irq without enable");
  AST_ACK_CLR: assert property (wr_ctl && pwdata_i[PTB_BIT_FLAG_ACK] && off_q == 2'h3
    && !pwdata_i[PTB_BIT_RUN_ENABLE] && mask_q == 2'h0 |=> !irq_o) else $error("ack ignored");
  AST_HOLD_OFF: assert property (off_q == 2'h3 && quiet |=> !irq_o)
    else $error("flag set while stopped");
  AST_STOP_FREEZE: assert property ((stop_mode_i && !osc_stop_keep_i && quiet) [*3]
    |=> !irq_o) else $error("counting in stop without oscillator");
  AST_WAKE: assert property (stop_mode_i && ie_q && mask_q == 2'h0 |-> wake_o == irq_o)
    else $error("wake does not follow request");
  AST_NO_WAKE: assert property (!stop_mode_i |-> !wake_o)
    else $error("wake outside stop");
  AST_FIRST: assert property (s_start |=> s_half)
    else $error("first event not near half period");
endmodule : ptb_top_asserts

// ### sim/tb_top.sv
// Self-checking bench for ptb_top over APB, one clock.
// Assumes OSC_DIV of 1 so one tick per bus clock.
`timescale 1ns/1ps
module tb_top;
  import ptb_pkg::*;
  logic clock_i = 0, rst_n_i = 0, psel = 0, pen = 0, pwr = 0;
  logic wmode = 0, smode = 0, keep = 0, er;
  logic [7:0] paddr = 8'h00;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] pwdata = 32'h0, rd;
  logic [31:0] prdata;
  logic pready, perr, irq, wake;
  int fail_count = 0, samples_checked = 0, cyc = 0, t0, t1, d;
  ptb_top #(.OSC_DIV(1)) uut (.clock_i(clock_i), .rst_n_i(rst_n_i), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(perr), .wait_mode_i(wmode),
    .stop_mode_i(smode), .osc_stop_keep_i(keep), .irq_o(irq), .wake_o(wake));
  always #12.5 clock_i = ~clock_i;
  // Cycle count for timing and the hang limit
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 70000) begin
      fail_count++;
      summarize();
    end
  end
  task summarize;
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // One APB transfer; request held until pready is seen
  task apb(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge clock_i);
    psel <= 1;
    pwr <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge clock_i);
    pen <= 1;
    do @(posedge clock_i); while (pready !== 1'b1);
    rd = prdata;
    er = perr;
    psel <= 0;
    pen <= 0;
  endtask : apb
  // Cycle of the next raised request, then back on a rising edge
  task wait_irq(output int t);
    do @(negedge clock_i); while (irq !== 1'b1);
    t = cyc;
    @(posedge clock_i);
  endtask : wait_irq
  initial begin
    repeat (5) @(posedge clock_i);
    rst_n_i <= 1;
    for (int a = 0; a < 16; a += 4) begin
      apb(0, 8'(a), 0);
      chk("reset value", 0, rd);
      chk("slverr", 32'(a == 12), {31'h0, er});
    end
    // Write without lane 0 must leave the mask untouched
    pstrb <= 4'he;
    apb(1, PTB_OFS_MASK, 3);
    pstrb <= 4'hf;
    apb(0, PTB_OFS_MASK, 0);
    chk("strobe", 0, rd);
    apb(1, PTB_OFS_CONTROL, 32'h74);
    apb(0, PTB_OFS_CONTROL, 0);
    chk("control", 32'h74, rd);
    repeat (20) @(negedge clock_i);
    chk("irq idle", 0, irq);
    // Each fast rate and the slowest affordable one
    for (int r = 3; r < 8; r++) begin
      d = r > 3 ? 64 >> (r - 4) : 32768;
      apb(1, PTB_OFS_CONTROL, 32'h0c | r << 4);
      apb(1, PTB_OFS_CONTROL, 32'h06 | r << 4);
      t0 = cyc;
      wait_irq(t1);
      chk("first", 1, 32'(t1 - t0 >= d / 2 && t1 - t0 <= d / 2 + 3));
      apb(1, PTB_OFS_CONTROL, 32'h0e | r << 4);
      wait_irq(t0);
      chk("period", 32'(d), 32'(t0 - t1));
    end
    apb(1, PTB_OFS_CONTROL, 32'h7e);
    wmode <= 1;
    apb(0, PTB_OFS_CONTROL, 0);
    chk("wait err", 1, {31'h0, er});
    apb(1, PTB_OFS_CONTROL, 0);
    wait_irq(t0);
    wmode <= 0;
    apb(0, PTB_OFS_CONTROL, 0);
    chk("wait run", 32'hf6, rd);
    apb(1, PTB_OFS_CONTROL, 32'h7e);
    smode <= 1;
    repeat (30) @(negedge clock_i);
    chk("stop frozen", 0, {irq, wake});
    @(posedge clock_i);
    keep <= 1;
    wait_irq(t0);
    chk("wake", 1, wake);
    smode <= 0;
    keep <= 0;
    apb(1, PTB_OFS_CONTROL, 32'h74);
    @(negedge clock_i);
    chk("ack zero", 1, irq);
    repeat (3) @(posedge clock_i);
    apb(1, PTB_OFS_CONTROL, 32'h7c);
    @(negedge clock_i);
    chk("ack one", 0, irq);
    apb(1, PTB_OFS_MASK, 1);
    apb(1, PTB_OFS_CONTROL, 32'h7a);
    repeat (12) @(posedge clock_i);
    apb(1, PTB_OFS_CONTROL, 32'h70);
    @(negedge clock_i);
    chk("masked status irq", 1, irq);
    apb(0, PTB_OFS_STATUS, 0);
    chk("status", 1, rd & 32'h1);
    apb(0, PTB_OFS_STATUS, 0);
    chk("status clear", 0, rd);
    @(negedge clock_i);
    chk("irq clear", 0, irq);
    apb(1, PTB_OFS_MASK, 0);
    // Timebase switched off before stop with the oscillator kept alive
    apb(1, PTB_OFS_CONTROL, 32'h7c);
    smode <= 1;
    keep <= 1;
    repeat (20) @(negedge clock_i);
    chk("stop disabled", 0, {irq, wake});
    summarize();
  end
endmodule : tb_top
bind ptb_top ptb_top_asserts #(.OSC_DIV(OSC_DIV)) u_chk (.clock_i(clock_i), .rst_n_i(rst_n_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .wait_mode_i(wait_mode_i), .stop_mode_i(stop_mode_i),
  .osc_stop_keep_i(osc_stop_keep_i), .irq_o(irq_o), .wake_o(wake_o));
